//--- logic/ddrcd_device.sv
// Memory-device end: registers command pins, decodes, keeps bank states.
// Assumes the controller shares mclk and meets bank-state preconditions.
`timescale 1ns/10ps
module ddrcd_device
  import ddrcd_pkg::*;
#(
  parameter int unsigned NBANK = BANKS,
  parameter bit OTF_EN = 1'b1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pins from the controller
  ddrcd_if.dev pins,
  // Decoded events
  output ddrcd_cmd_e cmd_q,
  output logic [BA_W-1:0] cmd_bank,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic auto_pre,
  output logic burst_chop,
  output logic [DQ_W-1:0] wr_data,
  output logic [DM_W-1:0] wr_lane_en,
  output logic [2:0] mr_sel,
  output logic [ADDR_W-1:0] mr_op,
  output logic illegal,
  // Device status
  output ddrcd_pwr_e pwr_state,
  output logic [NBANK-1:0] bank_open,
  output logic all_idle
);
  // Bank state is sized by the bank-select width, so a different count cannot be served
  if (NBANK != BANKS)
  begin : g_bad_nbank
    $error("ddrcd_device: NBANK must equal bank-select range");
  end

  typedef struct packed {
    logic cke_p;
    logic cke;
    logic [3:0] pin;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] a;
    logic [DM_W-1:0] dm;
    logic [DQ_W-1:0] dq;
    ddrcd_cmd_e cmd;
    logic [BA_W-1:0] obank;
    logic [ADDR_W-1:0] oaddr;
    logic ap;
    logic bc;
    logic [DQ_W-1:0] wd;
    logic [DM_W-1:0] wen;
    logic ill;
    ddrcd_pwr_e pwr;
    ddrcd_bank_e [BANKS-1:0] bk;
    logic [BANKS-1:0][CNT_W-1:0] rp;
  } ddrcd_dev_s;

  ddrcd_dev_s s_r;
  ddrcd_dev_s s_nxt;
  ddrcd_cmd_e dec;

  function automatic logic all_banks_idle(input ddrcd_bank_e [BANKS-1:0] b);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < BANKS; i++)
      ok = ok && (b[i] == BK_IDLE);
    return ok;
  endfunction

  ddrcd_classify u_cls (
    .cke_prev(s_r.cke_p),
    .cke_now(s_r.cke),
    .pins(s_r.pin),
    .ap(s_r.a[AP_BIT]),
    .cmd(dec)
  );

  always_comb
  begin
    s_nxt = s_r;
    // Pins captured on the clock's rising edge only
    s_nxt.cke_p = s_r.cke;
    s_nxt.cke = pins.cke;
    s_nxt.pin = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    s_nxt.ba = pins.ba;
    s_nxt.a = pins.addr;
    s_nxt.dm = pins.dm;
    s_nxt.dq = pins.dq;
    s_nxt.cmd = CMD_NONE;
    s_nxt.ill = 1'b0;
    s_nxt.wen = '0;
    // Precharge period counts down per bank
    for (int i = 0; i < BANKS; i++)
    begin
      if (s_r.bk[i] == BK_PRECH)
      begin
        if (s_r.rp[i] <= CNT_W'(1))
          s_nxt.bk[i] = BK_IDLE;
        else
          s_nxt.rp[i] = s_r.rp[i] - CNT_W'(1);
      end
    end
    if (s_r.pwr != PM_RUN)
    begin
      if (dec == CMD_PDX)
      begin
        s_nxt.pwr = PM_RUN;
        s_nxt.cmd = CMD_PDX;
      end
    end
    else
    begin
      s_nxt.cmd = dec;
      s_nxt.obank = s_r.ba;
      s_nxt.oaddr = s_r.a;
      s_nxt.ap = s_r.a[AP_BIT];
      // Chop when bit low; fixed setting reports eight
      s_nxt.bc = OTF_EN ? !s_r.a[BC_BIT] : 1'b0;
      unique case (dec)
        // Open row in the addressed bank
        CMD_ACT:
        begin
          if (s_r.bk[s_r.ba] == BK_IDLE)
            s_nxt.bk[s_r.ba] = BK_ACTIVE;
          else
            s_nxt.ill = 1'b1;
        end
        // Single bank precharge in any state
        CMD_PRE:
        begin
          s_nxt.bk[s_r.ba] = BK_PRECH;
          s_nxt.rp[s_r.ba] = CNT_W'(T_RP_CYC);
        end
        CMD_PREA:
        begin
          for (int i = 0; i < BANKS; i++)
          begin
            s_nxt.bk[i] = BK_PRECH;
            s_nxt.rp[i] = CNT_W'(T_RP_CYC);
          end
        end
        CMD_WR, CMD_RD:
        begin
          if (s_r.bk[s_r.ba] != BK_ACTIVE)
            s_nxt.ill = 1'b1;
          else
          begin
            if (dec == CMD_WR)
            begin
              s_nxt.wd = s_r.dq;
              // Each mask suppresses its own byte lane
              s_nxt.wen = ~s_r.dm;
            end
            // Auto-precharge puts the bank into precharge on the same edge as the access
            if (s_r.a[AP_BIT])
            begin
              s_nxt.bk[s_r.ba] = BK_PRECH;
              s_nxt.rp[s_r.ba] = CNT_W'(T_RP_CYC);
            end
          end
        end
        // Mode load, refresh, calibration: all idle
        CMD_MRS, CMD_REF, CMD_ZQL, CMD_ZQS:
          s_nxt.ill = !all_banks_idle(s_r.bk);
        CMD_SRE:
        begin
          if (all_banks_idle(s_r.bk))
            s_nxt.pwr = PM_SREF;
          else
            s_nxt.ill = 1'b1;
        end
        CMD_PDE:
          s_nxt.pwr = PM_PDOWN;
        CMD_ILL:
          s_nxt.ill = 1'b1;
        default:
          s_nxt.cmd = dec;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  always_comb
  begin
    bank_open = '0;
    for (int i = 0; i < BANKS; i++)
      bank_open[i] = (s_r.bk[i] == BK_ACTIVE);
  end

  assign cmd_q = s_r.cmd;
  assign cmd_bank = s_r.obank;
  assign cmd_addr = s_r.oaddr;
  assign auto_pre = s_r.ap;
  assign burst_chop = s_r.bc;
  assign wr_data = s_r.wd;
  assign wr_lane_en = s_r.wen;
  assign mr_sel = s_r.obank;
  assign mr_op = s_r.oaddr;
  assign illegal = s_r.ill;
  assign pwr_state = s_r.pwr;
  assign all_idle = all_banks_idle(s_r.bk);
endmodule // ddrcd_device

//--- shared/ddrcd_pkg.sv
// Package of the command decoder: command encodings, bank states, timing.
// Assumes one system clock mclk at 20 MHz shared by both ends.
package ddrcd_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BANKS = 8;
  localparam int unsigned BA_W = 3;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned DM_W = 2;
  // Row precharge time in picoseconds, and its least count of cycles
  localparam int unsigned T_RP_PS = 13_090;
  localparam int unsigned PS_PER_S_DIV = 1_000_000;
  localparam int unsigned T_RP_CYC_RAW =
    (T_RP_PS * (CLK_HZ / PS_PER_S_DIV) + 999_999) / 1_000_000;
  localparam int unsigned T_RP_CYC = (T_RP_CYC_RAW < 1) ? 1 : T_RP_CYC_RAW;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned BC_BIT = 12;
  localparam int unsigned CNT_W = 4;

  // Command field order: {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_WR = 4'h4;
  localparam logic [3:0] PIN_RD = 4'h5;
  localparam logic [3:0] PIN_MRS = 4'h0;
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_ZQ = 4'h6;

  typedef enum logic [3:0] {
    CMD_NONE = 4'b0000,
    CMD_ACT = 4'b0001,
    CMD_PRE = 4'b0010,
    CMD_PREA = 4'b0011,
    CMD_WR = 4'b0100,
    CMD_RD = 4'b0101,
    CMD_MRS = 4'b0110,
    CMD_REF = 4'b0111,
    CMD_SRE = 4'b1000,
    CMD_SRX = 4'b1001,
    CMD_PDE = 4'b1010,
    CMD_PDX = 4'b1011,
    CMD_ZQL = 4'b1100,
    CMD_ZQS = 4'b1101,
    CMD_ILL = 4'b1110
  } ddrcd_cmd_e;

  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_ACTIVE = 2'b01,
    BK_PRECH = 2'b10
  } ddrcd_bank_e;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_PDOWN = 2'b01,
    PM_SREF = 2'b10
  } ddrcd_pwr_e;
endpackage

//--- shared/ddrcd_if.sv
// Command pins between controller and memory device.
// Assumes both ends on mclk; the controller drives every signal.
`timescale 1ns/10ps
interface ddrcd_if;
  import ddrcd_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DM_W-1:0] dm;
  logic [DQ_W-1:0] dq;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq);
endinterface

//--- logic/ddrcd_classify.sv
// Pure command classifier: pin levels and clock-enable pair to a command.
// Assumes registered inputs from the same clock domain.
`timescale 1ns/10ps
module ddrcd_classify
  import ddrcd_pkg::*;
(
  // Clock-enable pair
  input wire logic cke_prev,
  input wire logic cke_now,
  // Command pins
  input wire logic [3:0] pins,
  input wire logic ap
  ,
  // Decoded command
  output ddrcd_cmd_e cmd
);
  always_comb
  begin
    cmd = CMD_ILL;
    if (!cke_prev && cke_now)
    begin
      if (pins[3] || pins == PIN_NOP)
        cmd = CMD_PDX;
    end
    else if (cke_prev && !cke_now)
    begin
      if (pins == PIN_REF)
        cmd = CMD_SRE;
      else if (pins[3] || pins == PIN_NOP)
        cmd = CMD_PDE;
    end
    else if (!cke_prev)
      cmd = CMD_NONE;
    else if (pins[3])
      cmd = CMD_NONE;
    else
    begin
      unique case (pins)
        PIN_ACT: cmd = CMD_ACT;
        PIN_PRE: cmd = ap ? CMD_PREA : CMD_PRE;
        PIN_WR: cmd = CMD_WR;
        PIN_RD: cmd = CMD_RD;
        PIN_MRS: cmd = CMD_MRS;
        PIN_REF: cmd = CMD_REF;
        PIN_ZQ: cmd = ap ? CMD_ZQL : CMD_ZQS;
        PIN_NOP: cmd = CMD_NONE;
        default: cmd = CMD_ILL;
      endcase
    end
  end
endmodule // ddrcd_classify

//--- logic/ddrcd_ctrl.sv
// Controller end: turns one-cycle user requests into pin commands.
// Assumes the device end shares mclk; holds off bank misuse itself, except an all-idle command sent before a precharge has settled.
`timescale 1ns/10ps
module ddrcd_ctrl
  import ddrcd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // User request
  input wire logic req_valid,
  input ddrcd_cmd_e req_cmd,
  input wire logic [BA_W-1:0] req_bank,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DQ_W-1:0] req_data,
  input wire logic [DM_W-1:0] req_mask,
  output logic req_ready,
  // Pins to the device
  ddrcd_if.ctrl pins
);
  typedef struct packed {
    logic cke;
    logic [3:0] pin;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] a;
    logic [DM_W-1:0] dm;
    logic [DQ_W-1:0] dq;
    logic [BANKS-1:0] open;
    logic [BANKS-1:0][CNT_W-1:0] rp;
  } ddrcd_ctl_s;

  ddrcd_ctl_s s_r;
  ddrcd_ctl_s s_nxt;
  logic ok;

  always_comb
  begin
    ok = 1'b1;
    unique case (req_cmd)
      // Activate only a closed, settled bank
      CMD_ACT: ok = !s_r.open[req_bank] && s_r.rp[req_bank] == '0;
      CMD_WR, CMD_RD: ok = s_r.open[req_bank];
      CMD_MRS, CMD_REF, CMD_SRE, CMD_ZQL, CMD_ZQS, CMD_PDE: ok = s_r.open == '0;
      default: ok = 1'b1;
    endcase
  end
  assign req_ready = ok;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pin = PIN_NOP;
    s_nxt.dm = '0;
    for (int i = 0; i < BANKS; i++)
      if (s_r.rp[i] != '0)
        s_nxt.rp[i] = s_r.rp[i] - CNT_W'(1);
    if (req_valid && ok)
    begin
      s_nxt.ba = req_bank;
      s_nxt.a = req_addr;
      s_nxt.dq = req_data;
      s_nxt.dm = req_mask;
      unique case (req_cmd)
        CMD_ACT:
        begin
          s_nxt.pin = PIN_ACT;
          s_nxt.open[req_bank] = 1'b1;
        end
        CMD_PRE, CMD_PREA:
        begin
          s_nxt.pin = PIN_PRE;
          s_nxt.a[AP_BIT] = (req_cmd == CMD_PREA);
          for (int i = 0; i < BANKS; i++)
            if (req_cmd == CMD_PREA || i == int'(req_bank))
            begin
              s_nxt.open[i] = 1'b0;
              s_nxt.rp[i] = CNT_W'(T_RP_CYC);
            end
        end
        CMD_WR, CMD_RD:
        begin
          s_nxt.pin = (req_cmd == CMD_WR) ? PIN_WR : PIN_RD;
          if (req_addr[AP_BIT])
          begin
            s_nxt.open[req_bank] = 1'b0;
            s_nxt.rp[req_bank] = CNT_W'(T_RP_CYC);
          end
        end
        CMD_MRS: s_nxt.pin = PIN_MRS;
        CMD_REF: s_nxt.pin = PIN_REF;
        CMD_ZQL, CMD_ZQS:
        begin
          s_nxt.pin = PIN_ZQ;
          s_nxt.a[AP_BIT] = (req_cmd == CMD_ZQL);
        end
        CMD_SRE:
        begin
          s_nxt.pin = PIN_REF;
          s_nxt.cke = 1'b0;
        end
        // Enable falls with a no-op presented
        CMD_PDE: s_nxt.cke = 1'b0;
        // Enable rises with a no-op presented
        CMD_PDX, CMD_SRX: s_nxt.cke = 1'b1;
        // Deselect; the other pins carry the load code, which must be ignored
        CMD_NONE: s_nxt.pin = {1'b1, PIN_MRS[2:0]};
        default: s_nxt.pin = PIN_NOP;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pins.cke = s_r.cke;
  assign pins.cs_n = s_r.pin[3];
  assign pins.ras_n = s_r.pin[2];
  assign pins.cas_n = s_r.pin[1];
  assign pins.we_n = s_r.pin[0];
  assign pins.ba = s_r.ba;
  assign pins.addr = s_r.a;
  assign pins.dm = s_r.dm;
  assign pins.dq = s_r.dq;
endmodule // ddrcd_ctrl

//--- bench/ddrcd_sva.sv
// Pin-level checks on the commands the controller end sends.
// Assumes both ends share mclk and arst_n.
`timescale 1ns/10ps
module ddrcd_sva
  import ddrcd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DM_W-1:0] dm,
  input wire logic [DQ_W-1:0] dq
);
  logic cke_r;
  logic [BANKS-1:0] open_r;
  logic [3:0] code;
  logic run;
  logic rw;
  assign code = {cs_n, ras_n, cas_n, we_n};
  assign run = cke_r && cke;
  assign rw = code == PIN_RD || code == PIN_WR;
  // Row mirror; a precharging bank already counts as closed
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cke_r <= 1'b0;
      open_r <= '0;
    end
    else
    begin
      cke_r <= cke;
      if (run && code == PIN_ACT)
        open_r[ba] <= 1'b1;
      else if (run && code == PIN_PRE && addr[AP_BIT])
        open_r <= '0;
      else if (run && (code == PIN_PRE || (rw && addr[AP_BIT])))
        open_r[ba] <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  a_act_bank_idle: assert property (run && code == PIN_ACT |-> !open_r[ba])
    else $error("activate to an open bank");
  a_rdwr_bank_open: assert property (run && rw |-> open_r[ba])
    else $error("access to an idle bank");
  a_mrs_all_idle: assert property (run && code == PIN_MRS |-> open_r == '0)
    else $error("mode load with a bank open");
  a_ref_all_idle: assert property (cke_r && code == PIN_REF |-> open_r == '0)
    else $error("refresh with a bank open");
  a_zq_all_idle: assert property (run && code == PIN_ZQ |-> open_r == '0)
    else $error("calibration with a bank open");
  a_sleep_idle: assert property ($fell(cke) && code == PIN_NOP |-> open_r == '0)
    else $error("power-down with a bank open");
  a_sleep_cmd: assert property ($fell(cke) |-> cs_n || code == PIN_NOP || code == PIN_REF)
    else $error("enable dropped with a wrong command");
  a_wake_cmd: assert property ($rose(cke) |-> cs_n || code == PIN_NOP)
    else $error("enable rose with a wrong command");
endmodule // ddrcd_sva

//--- bench/test_dram_command_decoder.sv
// Testbench: controller end facing device end, driven from the user side.
// Assumes one 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps
module test_dram_command_decoder;
  import ddrcd_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  ddrcd_cmd_e req_cmd = CMD_NONE;
  logic [BA_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DQ_W-1:0] req_data = '0;
  logic [DM_W-1:0] req_mask = '0;
  logic req_ready;
  ddrcd_cmd_e cmd_q;
  ddrcd_pwr_e pwr_state;
  logic [BA_W-1:0] cmd_bank;
  logic [ADDR_W-1:0] cmd_addr;
  logic auto_pre;
  logic burst_chop;
  logic [DQ_W-1:0] wr_data;
  logic [DM_W-1:0] wr_lane_en;
  logic [2:0] mr_sel;
  logic [ADDR_W-1:0] mr_op;
  logic illegal;
  logic [BANKS-1:0] bank_open;
  logic all_idle;
  int fails = 0;
  int checks = 0;
  always #25 mclk = ~mclk;
  ddrcd_if bus ();
  ddrcd_ctrl ddrcd_ctrl_i (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_data(req_data),
    .req_mask(req_mask), .req_ready(req_ready), .pins(bus));
  ddrcd_device #(.NBANK(BANKS), .OTF_EN(1'b1)) ddrcd_device_i (.mclk(mclk), .arst_n(arst_n),
    .pins(bus), .cmd_q(cmd_q), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .auto_pre(auto_pre),
    .burst_chop(burst_chop), .wr_data(wr_data), .wr_lane_en(wr_lane_en), .mr_sel(mr_sel),
    .mr_op(mr_op), .illegal(illegal), .pwr_state(pwr_state), .bank_open(bank_open),
    .all_idle(all_idle));
  ddrcd_sva ddrcd_sva_i (.mclk(mclk), .arst_n(arst_n), .cke(bus.cke), .cs_n(bus.cs_n),
    .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr),
    .dm(bus.dm), .dq(bus.dq));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One request, then its decoded command, two edges behind the pins
  task automatic issue(input ddrcd_cmd_e c, input logic [BA_W-1:0] b,
    input logic [ADDR_W-1:0] a, input ddrcd_cmd_e exp,
    input logic [DQ_W-1:0] d = '0, input logic [DM_W-1:0] m = '0);
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_data = d;
    req_mask = m;
    req_valid = 1'b1;
    #1;
    check(16'(req_ready), 16'(exp != CMD_NONE));
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (2) @(negedge mclk);
    check(16'(cmd_q), 16'(exp));
  endtask

  task automatic t_access;
    issue(CMD_ACT, 3'h5, 13'h1abc, CMD_ACT);
    check(16'(cmd_bank), 16'h0005);
    check(16'(cmd_addr), 16'h1abc);
    check(16'(bank_open), 16'h0020);
    // Idle cycles leave the open row alone
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      check(16'(cmd_q), 16'(CMD_NONE));
      check(16'(bank_open), 16'h0020);
    end
    // Deselect with the load code on the other pins must be ignored
    req_cmd = CMD_NONE;
    req_valid = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      check(16'(cmd_q), 16'(CMD_NONE));
      check(16'(bank_open), 16'h0020);
    end
    req_valid = 1'b0;
    repeat (2) @(negedge mclk);
    check(16'(illegal), 16'h0000);
    issue(CMD_WR, 3'h5, 13'h0008, CMD_WR, 16'hbeef, 2'b01);
    check(16'(burst_chop), 16'h0001);
    check(wr_data, 16'hbeef);
    check(16'(wr_lane_en), 16'h0002);
    issue(CMD_WR, 3'h5, 13'h1008, CMD_WR, 16'h1234, 2'b10);
    check(16'(wr_lane_en), 16'h0001);
    issue(CMD_RD, 3'h5, 13'h1010, CMD_RD);
    check(16'(burst_chop), 16'h0000);
    check(16'(cmd_addr), 16'h1010);
    check(16'(auto_pre), 16'h0000);
    issue(CMD_RD, 3'h3, 13'h0000, CMD_NONE);
    $display("test access done");
  endtask

  task automatic t_prech;
    issue(CMD_WR, 3'h5, 13'h0400, CMD_WR);
    check(16'(auto_pre), 16'h0001);
    check(16'(bank_open), 16'h0000);
    issue(CMD_ACT, 3'h1, 13'h0011, CMD_ACT);
    issue(CMD_ACT, 3'h6, 13'h0066, CMD_ACT);
    issue(CMD_PRE, 3'h1, 13'h0000, CMD_PRE);
    check(16'(bank_open), 16'h0040);
    issue(CMD_PRE, 3'h1, 13'h0000, CMD_PRE);
    check(16'(illegal), 16'h0000);
    issue(CMD_PREA, 3'h0, 13'h0400, CMD_PREA);
    check(16'(bank_open), 16'h0000);
    $display("test precharge done");
  endtask

  task automatic t_idle;
    issue(CMD_ACT, 3'h0, 13'h0000, CMD_ACT);
    issue(CMD_MRS, 3'h2, 13'h0123, CMD_NONE);
    issue(CMD_PRE, 3'h0, 13'h0000, CMD_PRE);
    issue(CMD_MRS, 3'h2, 13'h0123, CMD_MRS);
    check(16'(mr_sel), 16'h0002);
    check(16'(mr_op), 16'h0123);
    check(16'(all_idle), 16'h0001);
    issue(CMD_REF, 3'h0, 13'h0000, CMD_REF);
    issue(CMD_ZQL, 3'h0, 13'h0400, CMD_ZQL);
    issue(CMD_ZQS, 3'h0, 13'h0000, CMD_ZQS);
    $display("test idle commands done");
  endtask

  task automatic t_power;
    issue(CMD_PDE, 3'h0, 13'h0000, CMD_PDE);
    check(16'(pwr_state), 16'(PM_PDOWN));
    issue(CMD_PDX, 3'h0, 13'h0000, CMD_PDX);
    check(16'(pwr_state), 16'(PM_RUN));
    issue(CMD_SRE, 3'h0, 13'h0000, CMD_SRE);
    check(16'(pwr_state), 16'(PM_SREF));
    issue(CMD_PDX, 3'h0, 13'h0000, CMD_PDX);
    check(16'(pwr_state), 16'(PM_RUN));
    $display("test power done");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang counts as a mismatch
  initial
  begin
    repeat (3000) @(posedge mclk);
    fails++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    issue(CMD_PDX, 3'h0, 13'h0000, CMD_PDX);
    t_access();
    t_prech();
    t_idle();
    t_power();
    report_and_stop();
  end
endmodule // test_dram_command_decoder
